// ==== testbench/spi_frame_engine_sva.sv ====
// Purpose: port checks on the frame engine
// Assumes: select held high during reset
// Notes: all checks run on clock_i
module spi_frame_engine_sva
  import spi_frame_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // watched ports
  input wire logic frame_select_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire block_kind_t block_kind_o,
  input wire logic frame_active_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // checks
  // ****************
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_req; mem_rd_o || mem_wr_o; endsequence
  sequence s_sel_low; $fell(frame_select_n_i) ##1 !frame_select_n_i; endsequence
  a_rd_one_cycle: assert property (mem_rd_o |=> !mem_rd_o) else $error("read strobe too long");
  a_wr_one_cycle: assert property (mem_wr_o |=> !mem_wr_o) else $error("write strobe too long");
  a_reserved_quiet: assert property (s_req |-> block_kind_o != BLK_RESERVED) else $error("reserved access");
  a_idle_no_drive: assert property (frame_select_n_i && $past(frame_select_n_i) |-> !miso_oe_o)
    else $error("miso driven while idle");
  a_miso_low_off: assert property (!miso_oe_o |-> !miso_o) else $error("miso high while not driving");
  a_write_no_drive: assert property (mem_wr_o |-> !miso_oe_o) else $error("miso driven in write");
  a_addr_moves_req: assert property ($changed(mem_addr_o) |-> s_req) else $error("address moved alone");
  a_frame_follows: assert property (s_sel_low |-> ##[0:3] frame_active_o) else $error("frame not seen");
  a_frame_ends: assert property ($rose(frame_select_n_i) |-> ##[1:4] !frame_active_o)
    else $error("frame end not seen");
endmodule : spi_frame_engine_sva

bind spi_frame_engine spi_frame_engine_sva #(.SYNC_STAGES(SYNC_STAGES)) spi_frame_engine_sva_i (
  .clock_i(clock_i), .rst_i(rst_i), .frame_select_n_i(frame_select_n_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
  .block_kind_o(block_kind_o), .frame_active_o(frame_active_o)
);

// ==== testbench/spi_frame_engine_tb.sv ====
// Purpose: self-checking bench for the frame engine
// Assumes: memory answers reads 1 to 6 cycles late
// Notes: expected bytes come from the bench memory formula
`define check(got, want) begin samples_checked++; if ((got) !== (want)) begin errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module spi_frame_engine_tb
  import spi_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, rst_i, sclk, sel_n, mosi, miso, miso_oe, mem_rd, mem_wr, rd_valid;
  logic frame_active, fixed_mode, overrun, overrun_clear;
  logic [15:0] mem_addr;
  logic [7:0] wr_data, rd_data;
  logic [2:0] socket;
  block_kind_t kind;
  logic [29:0] exp_wr[$];
  logic [29:0] exp_word;
  int errors = 0, samples_checked = 0, seed = 77;

  spi_frame_engine spi_frame_engine_i (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
    .frame_select_n_i(sel_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .mem_rd_o(mem_rd),
    .mem_wr_o(mem_wr), .mem_addr_o(mem_addr), .mem_wr_data_o(wr_data), .block_kind_o(kind),
    .socket_o(socket), .mem_rd_data_i(rd_data), .mem_rd_valid_i(rd_valid), .frame_active_o(frame_active),
    .fixed_length_mode_o(fixed_mode), .read_overrun_o(overrun), .read_overrun_clear_i(overrun_clear));
  spi_host_model spi_host_model_i (.sclk_o(sclk), .frame_select_n_o(sel_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));

  // ****************
  // memory side
  // ****************
  function automatic logic [7:0] mem_val(input logic [2:0] k, input logic [2:0] s, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {s, 2'h0, k};
  endfunction : mem_val
  function automatic logic [5:0] decode(input logic [4:0] b);
    logic [2:0] k;
    k = (b == 5'h00) ? 3'h0 : (b[1:0] == 2'h0) ? 3'h4 : {1'b0, b[1:0]};
    return {k, b[4:2]};
  endfunction : decode
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    rd_valid = 1'b0;
    rd_data = 8'h00;
    forever begin
      @(negedge clock_i);
      if (mem_rd === 1'b1) begin
        repeat (1 + $unsigned($random(seed)) % 6) @(negedge clock_i);
        rd_valid = 1'b1;
        rd_data = mem_val(kind, socket, mem_addr);
        @(negedge clock_i) rd_valid = 1'b0;
      end
      if (mem_wr === 1'b1) begin
        if (exp_wr.size() == 0) begin
          `check(mem_wr, 1'b0)
        end else begin
          // pop once: the compare macro names its arguments twice
          exp_word = exp_wr.pop_front();
          `check({kind, socket, mem_addr, wr_data}, exp_word)
        end
      end
    end
  end
  initial begin
    repeat (80000) @(posedge clock_i);
    errors++;
    end_sim();
  end

  // ****************
  // frames
  // ****************
  task automatic frame(input logic [15:0] a, input logic [4:0] b, input logic rw, input logic [1:0] om,
      input int n, input logic fixed, input int gap, input int tail);
    logic [7:0] rx, tx;
    logic [5:0] d;
    d = decode(b);
    if (!fixed) spi_host_model_i.open_frame();
    spi_host_model_i.put_bits(a[15:8], 8, rx);
    spi_host_model_i.put_bits(a[7:0], 8, rx);
    spi_host_model_i.put_bits({b, rw, om}, 8, rx);
    for (int i = 0; i < n; i++) begin
      tx = 8'($random(seed));
      if (rw) exp_wr.push_back({d, a + 16'(i), tx});
      spi_host_model_i.put_bits(tx, 8, rx);
      if (!rw) `check(rx, (d[5:3] == 3'h4) ? 8'h00 : mem_val(d[5:3], d[2:0], a + 16'(i)))
      #(gap);
    end
    if (tail > 0) spi_host_model_i.put_bits(tx, tail, rx);
    if (!fixed) spi_host_model_i.close_frame();
  endtask : frame
  task automatic wait_idle();
    for (int t = 0; t < 200 && (frame_active !== 1'b0 || exp_wr.size() != 0); t++) @(negedge clock_i);
    if (frame_active !== 1'b0 || exp_wr.size() != 0) begin
      errors++;
      end_sim();
    end
  endtask : wait_idle
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    rst_i = 1'b1;
    overrun_clear = 1'b1;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    @(negedge clock_i) overrun_clear = 1'b0;
    #7;
    frame(16'h0003, 5'b11101, RW_READ, LEN_VAR, 1, 1'b0, 0, 0);
    frame(16'h0100, 5'b01111, RW_READ, LEN_VAR, 5, 1'b0, 400, 0);
    frame(16'h0040, 5'b00100, RW_READ, LEN_VAR, 2, 1'b0, 0, 0);
    frame(16'h0018, 5'b00000, RW_WRITE, LEN_VAR, 1, 1'b0, 0, 0);
    frame(16'h0018, 5'b00000, RW_READ, LEN_VAR, 1, 1'b0, 0, 0);
    // a half byte before the abort must never reach memory
    frame(16'hFFFF, 5'b00110, RW_WRITE, LEN_VAR, 2, 1'b0, 0, 4);
    wait_idle();
    `check(fixed_mode, 1'b0)
    spi_host_model_i.open_frame();
    for (int k = 0; k < 6; k++) begin
      frame(16'($random(seed)), {3'($random(seed)), 2'(1 + k % 3)}, k[0], 2'(1 + k / 2),
        (k / 2 == 2) ? 4 : 1 + k / 2, 1'b1, 0, 0);
    end
    spi_host_model_i.close_frame();
    wait_idle();
    `check(fixed_mode, 1'b1)
    `check(overrun, 1'b0)
    end_sim();
  end
endmodule : spi_frame_engine_tb

// ==== testbench/spi_host_model.sv ====
// Purpose: host serial master, clock mode 0
// Assumes: 48 ns link clock, standing low outside frames
// Notes: mosi shows the inverse of its last bit once released
module spi_host_model (
  // serial link
  output logic sclk_o,
  output logic frame_select_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    frame_select_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ****************
  // bit level
  // ****************
  task automatic put_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = tx[i];
      #24 sclk_o = 1'b1;
      rx[i] = miso_oe_i ? miso_i : 1'bx;
      #24 sclk_o = 1'b0;
    end
  endtask : put_bits
  task automatic open_frame();
    frame_select_n_o = 1'b0;
    #30;
  endtask : open_frame
  task automatic close_frame();
    #30 frame_select_n_o = 1'b1;
    mosi_o = ~mosi_o;
    // select stays high a full link period so the next fall is a real edge
    #48;
  endtask : close_frame
endmodule : spi_host_model

// ==== verilog/block_decode.sv ====
// Purpose: turn the five block select bits into a block kind and socket
// Assumes: upper three bits name the socket, lower two the region
// Notes: socket region 00 other than block zero is reserved
module block_decode
  import spi_frame_pkg::*;
(
  // select in
  input wire logic [BSB_W-1:0] block_i,
  // decoded
  output block_kind_t kind_o,
  output logic [2:0] socket_o
);

  always_comb begin
    socket_o = block_i[4:2];
    if (block_i == BSB_COMMON) begin
      kind_o = BLK_COMMON;
    end else if (block_i[1:0] == SEL_REG) begin
      kind_o = BLK_SOCK_REG;
    end else if (block_i[1:0] == SEL_TX) begin
      kind_o = BLK_SOCK_TX;
    end else if (block_i[1:0] == SEL_RX) begin
      kind_o = BLK_SOCK_RX;
    end else begin
      kind_o = BLK_RESERVED;
    end
  end

endmodule : block_decode

// ==== verilog/spi_frame_engine.sv ====
// Purpose: serial slave frame engine, variable and fixed length data phases
// Assumes: clock mode 0, sclk idle outside frames, 1-cycle-or-later memory read
// Notes: link logic on sclk_i, memory side on clock_i; reads are prefetched
module spi_frame_engine
  import spi_frame_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // system clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // serial link
  input wire logic sclk_i,
  input wire logic frame_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // memory access
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [BYTE_W-1:0] mem_wr_data_o,
  output block_kind_t block_kind_o,
  output logic [2:0] socket_o,
  input wire logic [BYTE_W-1:0] mem_rd_data_i,
  input wire logic mem_rd_valid_i,
  // status
  output logic frame_active_o,
  output logic fixed_length_mode_o,
  output logic read_overrun_o,
  input wire logic read_overrun_clear_i
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("spi_frame_engine needs at least two sync stages");
  end

  // ****************************************
  // link domain state
  // ****************************************
  link_state_t state;
  logic link_rst;
  logic [4:0] hdr_cnt;
  logic [HDR_SH_W-1:0] hdr_sh;
  logic [2:0] bit_cnt;
  logic [2:0] byte_left;
  logic [BYTE_W-2:0] data_sh;
  logic [BYTE_W-2:0] tx_sh;
  logic is_read;
  logic fixed;
  logic [ADDR_W-1:0] link_addr;
  logic [BSB_W-1:0] link_block;
  logic in_hdr;
  logic last_fixed_byte;

  // crossing words, held stable between toggles
  logic rd_tog;
  logic wr_tog;
  logic [ADDR_W-1:0] req_addr;
  logic [BSB_W-1:0] req_block;
  logic [BYTE_W-1:0] req_data;
  logic req_fixed;

  // system domain
  logic rd_pulse;
  logic wr_pulse;
  block_kind_t dec_kind;
  logic [2:0] dec_socket;
  logic [BYTE_W-1:0] rd_word;
  logic rd_outstanding;
  logic [SYNC_STAGES-1:0] sel_sync;

  // frame select high both ends a variable frame and holds the parser idle
  assign link_rst = rst_i | frame_select_n_i;
  assign in_hdr = (state == LINK_ADDR) || (state == LINK_CTRL);
  assign last_fixed_byte = fixed && (byte_left == BYTES_ONE);

  // ****************************************
  // header and data capture, rising edge
  // ****************************************
  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      state <= LINK_ADDR;
      hdr_cnt <= '0;
      hdr_sh <= '0;
      bit_cnt <= '0;
      byte_left <= '0;
      data_sh <= '0;
      is_read <= 1'b0;
      fixed <= 1'b0;
      link_addr <= '0;
      link_block <= '0;
    end else begin
      case (state)
        LINK_ADDR, LINK_CTRL: begin
          hdr_sh <= {hdr_sh[HDR_SH_W-2:0], mosi_i};
          hdr_cnt <= hdr_cnt + 5'h01;
          if (hdr_cnt == ADDR_LAST_CNT) begin
            state <= LINK_CTRL;
          end
          if (hdr_cnt == RWB_CNT) begin
            link_addr <= hdr_sh[20:5];
            link_block <= hdr_sh[4:0];
            is_read <= (mosi_i == RW_READ);
          end
          if (hdr_cnt == HDR_LAST_CNT) begin
            state <= LINK_DATA;
            fixed <= ({hdr_sh[0], mosi_i} != LEN_VAR);
            byte_left <= fixed_bytes({hdr_sh[0], mosi_i});
            bit_cnt <= BIT_FIRST;
          end
        end
        LINK_DATA: begin
          data_sh <= {data_sh[BYTE_W-3:0], mosi_i};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            link_addr <= link_addr + 16'h0001;
            if (fixed) begin
              byte_left <= byte_left - 3'h1;
              if (byte_left == BYTES_ONE) begin
                state <= LINK_ADDR;
                hdr_cnt <= '0;
              end
            end
          end
        end
        default: begin
          state <= LINK_ADDR;
        end
      endcase
    end
  end

  // ****************************************
  // requests toward the system domain
  // ****************************************
  // toggles survive frame ends so a frame edge never fakes an event
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_tog <= 1'b0;
      wr_tog <= 1'b0;
      req_addr <= '0;
      req_block <= '0;
      req_data <= '0;
      req_fixed <= 1'b0;
    end else if (!frame_select_n_i) begin
      if (in_hdr && (hdr_cnt == RWB_CNT) && (mosi_i == RW_READ)) begin
        // first byte fetched early: 2.5 sclk periods before it is shifted
        req_addr <= hdr_sh[20:5];
        req_block <= hdr_sh[4:0];
        rd_tog <= ~rd_tog;
      end else if ((state == LINK_DATA) && is_read && (bit_cnt == BIT_FIRST) && !last_fixed_byte) begin
        req_addr <= link_addr + 16'h0001;
        req_block <= link_block;
        req_fixed <= fixed;
        rd_tog <= ~rd_tog;
      end else if ((state == LINK_DATA) && !is_read && (bit_cnt == BIT_LAST)) begin
        req_addr <= link_addr;
        req_block <= link_block;
        req_data <= {data_sh, mosi_i};
        req_fixed <= fixed;
        wr_tog <= ~wr_tog;
      end
    end
  end

  // ****************************************
  // read data out, falling edge
  // ****************************************
  // rd_word is settled well before the falling edge that loads it
  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      tx_sh <= '0;
    end else begin
      miso_oe_o <= (state == LINK_DATA) && is_read;
      if ((state == LINK_DATA) && is_read) begin
        if (bit_cnt == BIT_FIRST) begin
          miso_o <= rd_word[BYTE_W-1];
          tx_sh <= rd_word[BYTE_W-2:0];
        end else begin
          miso_o <= tx_sh[BYTE_W-2];
          tx_sh <= {tx_sh[BYTE_W-3:0], 1'b0};
        end
      end else begin
        miso_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // crossing into the system clock
  // ****************************************
  toggle_sync #(
    .STAGES(SYNC_STAGES)
  ) u_rd_sync (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .toggle_i(rd_tog),
    .pulse_o(rd_pulse)
  );

  toggle_sync #(
    .STAGES(SYNC_STAGES)
  ) u_wr_sync (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .toggle_i(wr_tog),
    .pulse_o(wr_pulse)
  );

  block_decode u_decode (
    .block_i(req_block),
    .kind_o(dec_kind),
    .socket_o(dec_socket)
  );

  // ****************************************
  // memory access
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wr_data_o <= '0;
      block_kind_o <= BLK_COMMON;
      socket_o <= '0;
      fixed_length_mode_o <= 1'b0;
    end else begin
      mem_rd_o <= rd_pulse && (dec_kind != BLK_RESERVED);
      mem_wr_o <= wr_pulse && (dec_kind != BLK_RESERVED);
      // refused blocks make no request, so address, block and mode of the last real access stay on show; write data still loads
      if ((rd_pulse || wr_pulse) && (dec_kind != BLK_RESERVED)) begin
        mem_addr_o <= req_addr;
        block_kind_o <= dec_kind;
        socket_o <= dec_socket;
        fixed_length_mode_o <= req_fixed;
      end
      if (wr_pulse) begin
        mem_wr_data_o <= req_data;
      end
    end
  end

  // reserved blocks answer with a constant instead of a memory read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_word <= RD_WORD_RESET;
    end else if (rd_pulse && (dec_kind == BLK_RESERVED)) begin
      rd_word <= RESERVED_READ;
    end else if (mem_rd_valid_i) begin
      rd_word <= mem_rd_data_i;
    end
  end

  // a new fetch before the last returned means a byte went out stale
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_outstanding <= 1'b0;
      read_overrun_o <= 1'b0;
    end else begin
      if (mem_rd_o) begin
        rd_outstanding <= 1'b1;
      end else if (mem_rd_valid_i) begin
        rd_outstanding <= 1'b0;
      end
      if (rd_pulse && rd_outstanding) begin
        read_overrun_o <= 1'b1;
      end else if (read_overrun_clear_i) begin
        read_overrun_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // frame status
  // ****************************************
  // tied-low select in fixed mode shows as permanently active
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_sync <= '1;
      frame_active_o <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[SYNC_STAGES-2:0], frame_select_n_i};
      frame_active_o <= ~sel_sync[SYNC_STAGES-1];
    end
  end

endmodule : spi_frame_engine

// ==== verilog/spi_frame_pkg.sv ====
// Purpose: shared constants and types of the serial frame engine
// Assumes: 16-bit offset, 5-bit block select, 1 direction bit, 2 length bits
// Notes: every field position and count used by more than one file lives here
package spi_frame_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int BSB_W = 5;
  localparam int BYTE_W = 8;
  localparam int HDR_SH_W = 23;
  localparam logic [4:0] ADDR_LAST_CNT = 5'h0F;
  localparam logic [4:0] RWB_CNT = 5'h15;
  localparam logic [4:0] HDR_LAST_CNT = 5'h17;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // ****************************************
  // control phase encodings
  // ****************************************
  localparam logic RW_READ = 1'b0;
  localparam logic RW_WRITE = 1'b1;
  localparam logic [1:0] LEN_VAR = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;
  localparam logic [2:0] BYTES_ONE = 3'h1;
  localparam logic [2:0] BYTES_TWO = 3'h2;
  localparam logic [2:0] BYTES_FOUR = 3'h4;

  // ****************************************
  // block select encodings
  // ****************************************
  localparam logic [4:0] BSB_COMMON = 5'h00;
  localparam logic [1:0] SEL_REG = 2'h1;
  localparam logic [1:0] SEL_TX = 2'h2;
  localparam logic [1:0] SEL_RX = 2'h3;

  // ****************************************
  // reset and reserved read values
  // ****************************************
  localparam logic [7:0] RD_WORD_RESET = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;

  typedef enum logic [1:0] {
    LINK_ADDR = 2'b00,
    LINK_CTRL = 2'b01,
    LINK_DATA = 2'b11
  } link_state_t;

  typedef enum logic [2:0] {
    BLK_COMMON = 3'h0,
    BLK_SOCK_REG = 3'h1,
    BLK_SOCK_TX = 3'h2,
    BLK_SOCK_RX = 3'h3,
    BLK_RESERVED = 3'h4
  } block_kind_t;

  function automatic logic [2:0] fixed_bytes(input logic [1:0] mode);
    logic [2:0] n;
    n = BYTES_ONE;
    case (mode)
      LEN_TWO: n = BYTES_TWO;
      LEN_FOUR: n = BYTES_FOUR;
      default: n = BYTES_ONE;
    endcase
    return n;
  endfunction : fixed_bytes

endpackage : spi_frame_pkg

// ==== verilog/toggle_sync.sv ====
// Purpose: carry a toggle event from another clock into clk_i as a pulse
// Assumes: the toggle changes at most once per several destination cycles
// Notes: first stage is read only by the second stage
module toggle_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // event
  input wire logic toggle_i,
  output logic pulse_o
);

  logic [STAGES-1:0] chain;
  logic last;

  if (STAGES < 2) begin : g_bad_stages
    $error("toggle_sync needs at least two stages");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain <= '0;
      last <= 1'b0;
    end else begin
      chain <= {chain[STAGES-2:0], toggle_i};
      last <= chain[STAGES-1];
    end
  end

  assign pulse_o = chain[STAGES-1] ^ last;

endmodule : toggle_sync
